// ### rtl/pagpio_top.sv
/*
 Port A eight-pin GPIO with pin interrupt logic and an AXI4-Lite register file.
 Assumes pad cells that drive o_pin_out where o_pin_oe is high, apply the
 pull outputs, and return the pad level asynchronously on i_pin.
*/
// Summary of operation
// - Direction 0: driver off, read live pin
// - Direction 1: driver on, read latch
// - Pull enable bit turns input pull on
// - Output pins never get a pull
// - Pull-down only for selected high-polarity pins
// - Slew control acts on outputs only
// - Drive strength acts on outputs only
// - Flag bit 3 read-only, set on detection
// - Acknowledge bit 2 clears flag, reads 0
// - Request when flag and enable, or on an event bit whose mask bit is set
// - Mode bit 0: edges, or edges and levels
// - Pin select includes pin in detection
// - Polarity 0: falling/low, pull-up
// - Polarity 1: rising/high, pull-down
// - Edge is deasserted sample then asserted sample
// - Level mode: ack blocked while pin asserted
// - Data writes latch all bits, outputs drive
// - Reset: latch zero, inputs, pulls off
`timescale 1ns/1ps
`include "pagpio_params.svh"
module pagpio_top
	import pagpio_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire pagpio_axil_req_type i_axil,
	output pagpio_axil_rsp_type o_axil,
	input wire logic [7:0] i_pin,
	output logic [7:0] o_pin_out,
	output logic [7:0] o_pin_oe,
	output logic [7:0] o_pull_enable,
	output logic [7:0] o_pull_down,
	output logic [7:0] o_slew_enable,
	output logic [7:0] o_drive_high,
	output logic o_irq
);

	typedef struct packed {
		logic [7:0] port_data_latch;
		logic [7:0] port_direction;
		logic [7:0] pull_enable;
		logic [7:0] slew_rate_enable;
		logic [7:0] drive_strength_select;
		logic pin_irq_flag;
		logic pin_irq_request_enable;
		logic pin_irq_detect_mode;
		logic [7:0] pin_irq_select;
		logic [7:0] pin_irq_polarity_select;
		logic [7:0] evt_status;
		logic [7:0] evt_mask;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync_prev;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic [7:0] pull_on;
		logic [7:0] pull_down;
		logic [7:0] slew_on;
		logic [7:0] drive_high;
		logic irq;
	} pagpio_top_state_type;

	pagpio_top_state_type st;
	pagpio_top_state_type next_st;
	pagpio_acc_type acc;
	logic [7:0] rd_byte;
	logic [7:0] lvl_now;
	logic [7:0] lvl_prev;
	logic [7:0] edge_hit;
	logic [7:0] detect;
	logic ack_wr;
	logic level_held;

	pagpio_axil u_axil (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_axil(i_axil),
		.o_axil(o_axil),
		.o_acc(acc),
		.i_rdata(rd_byte)
	);

	// Level counts as asserted when it matches the polarity bit
	function automatic logic pin_asserted(input logic level, input logic pol);
		return level == pol;
	endfunction : pin_asserted

	// Per-pin detection works on the second sync stage and its delayed copy
	for (genvar i = 0; i < 8; i++) begin : g_pin
		assign lvl_now[i] = st.pin_irq_select[i] &&
			pin_asserted(st.sync2[i], st.pin_irq_polarity_select[i]);
		assign lvl_prev[i] = st.pin_irq_select[i] &&
			pin_asserted(st.sync_prev[i], st.pin_irq_polarity_select[i]);
		assign edge_hit[i] = lvl_now[i] && !lvl_prev[i];
		assign detect[i] = edge_hit[i] || (lvl_now[i] && st.pin_irq_detect_mode);
	end

	assign ack_wr = acc.wr && (acc.wsel == PAGPIO_REG_SC) && acc.wdata[`PAGPIO_SC_ACK];
	assign level_held = st.pin_irq_detect_mode && (|lvl_now);

	always_comb begin
		rd_byte = `PAGPIO_RST_BYTE;
		unique case (acc.rsel)
			PAGPIO_REG_DATA: rd_byte = (st.port_direction & st.port_data_latch) |
				(~st.port_direction & st.sync2);
			PAGPIO_REG_DIR: rd_byte = st.port_direction;
			PAGPIO_REG_PULL: rd_byte = st.pull_enable;
			PAGPIO_REG_SLEW: rd_byte = st.slew_rate_enable;
			PAGPIO_REG_DRIVE: rd_byte = st.drive_strength_select;
			PAGPIO_REG_SC: begin
				rd_byte[`PAGPIO_SC_FLAG] = st.pin_irq_flag;
				rd_byte[`PAGPIO_SC_ACK] = 1'b0;
				rd_byte[`PAGPIO_SC_IE] = st.pin_irq_request_enable;
				rd_byte[`PAGPIO_SC_MODE] = st.pin_irq_detect_mode;
			end
			PAGPIO_REG_PSEL: rd_byte = st.pin_irq_select;
			PAGPIO_REG_POL: rd_byte = st.pin_irq_polarity_select;
			PAGPIO_REG_EVT: rd_byte = st.evt_status;
			PAGPIO_REG_MASK: rd_byte = st.evt_mask;
			PAGPIO_REG_NONE: rd_byte = `PAGPIO_RST_BYTE;
		endcase
	end

	always_comb begin
		next_st = st;
		// Pin is asynchronous; only sync2 onward feeds logic
		next_st.sync1 = i_pin;
		next_st.sync2 = st.sync1;
		next_st.sync_prev = st.sync2;
		if (acc.wr) begin
			unique case (acc.wsel)
				PAGPIO_REG_DATA: next_st.port_data_latch = acc.wdata;
				PAGPIO_REG_DIR: next_st.port_direction = acc.wdata;
				PAGPIO_REG_PULL: next_st.pull_enable = acc.wdata;
				PAGPIO_REG_SLEW: next_st.slew_rate_enable = acc.wdata;
				PAGPIO_REG_DRIVE: next_st.drive_strength_select = acc.wdata;
				PAGPIO_REG_SC: begin
					// Flag position is ignored on writes
					next_st.pin_irq_request_enable = acc.wdata[`PAGPIO_SC_IE];
					next_st.pin_irq_detect_mode = acc.wdata[`PAGPIO_SC_MODE];
				end
				PAGPIO_REG_PSEL: next_st.pin_irq_select = acc.wdata;
				PAGPIO_REG_POL: next_st.pin_irq_polarity_select = acc.wdata;
				PAGPIO_REG_EVT: next_st.evt_status = st.evt_status & ~acc.wdata;
				PAGPIO_REG_MASK: next_st.evt_mask = acc.wdata;
				PAGPIO_REG_NONE: next_st.evt_mask = st.evt_mask;
			endcase
		end
		// In level mode, acknowledge only works once every asserted level has gone
		if (ack_wr && !level_held) begin
			next_st.pin_irq_flag = 1'b0;
		end
		// Set after clear, so an event in the ack cycle is kept
		if (|detect) begin
			next_st.pin_irq_flag = 1'b1;
		end
		next_st.evt_status = next_st.evt_status | detect;
		next_st.pin_out = next_st.port_data_latch;
		next_st.pin_oe = next_st.port_direction;
		next_st.pull_on = next_st.pull_enable & ~next_st.port_direction;
		next_st.pull_down = next_st.pull_on & next_st.pin_irq_select &
			next_st.pin_irq_polarity_select;
		next_st.slew_on = next_st.slew_rate_enable & next_st.port_direction;
		next_st.drive_high = next_st.drive_strength_select & next_st.port_direction;
		next_st.irq = (next_st.pin_irq_flag && next_st.pin_irq_request_enable) ||
			(|(next_st.evt_status & next_st.evt_mask));
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pin_out = st.pin_out;
	assign o_pin_oe = st.pin_oe;
	assign o_pull_enable = st.pull_on;
	assign o_pull_down = st.pull_down;
	assign o_slew_enable = st.slew_on;
	assign o_drive_high = st.drive_high;
	assign o_irq = st.irq;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence pin_edge_s;
		|edge_hit;
	endsequence

	sequence ack_clear_s;
		ack_wr && !level_held && !(|detect);
	endsequence

	sequence sc_plain_write_s;
		acc.wr && (acc.wsel == PAGPIO_REG_SC) && !acc.wdata[`PAGPIO_SC_ACK] && !(|detect);
	endsequence

	property data_write_p;
		acc.wr && (acc.wsel == PAGPIO_REG_DATA) |=> ##1 o_pin_out == $past(acc.wdata, 2);
	endproperty

	data_latch_out_a: assert property (data_write_p)
		else $error("Data write not driven on pins");

	dir_drives_oe_a: assert property (o_pin_oe == st.port_direction)
		else $error("Output enable differs from direction");

	data_read_mux_a: assert property (acc.rsel == PAGPIO_REG_DATA |->
		rd_byte == ((st.port_direction & st.port_data_latch) | (~st.port_direction & st.sync2)))
		else $error("Data read returns wrong source");

	pull_output_off_a: assert property ((o_pull_enable & o_pin_oe) == 8'h00)
		else $error("Pull active on output pin");

	pull_down_sel_a: assert property (
		(o_pull_down & ~(o_pull_enable & st.pin_irq_select & st.pin_irq_polarity_select)) == 8'h00)
		else $error("Pull-down outside selected high-polarity pin");

	slew_drive_in_a: assert property (((o_slew_enable | o_drive_high) & ~o_pin_oe) == 8'h00)
		else $error("Slew or drive active on input pin");

	edge_sets_flag_a: assert property (pin_edge_s |=> st.pin_irq_flag)
		else $error("Edge did not set the flag");

	level_holds_flag_a: assert property (ack_wr && level_held |=> st.pin_irq_flag)
		else $error("Flag cleared while level asserted");

	ack_clears_flag_a: assert property (ack_clear_s |=> !st.pin_irq_flag)
		else $error("Acknowledge did not clear the flag");

	flag_write_ro_a: assert property (
		sc_plain_write_s |=> st.pin_irq_flag == $past(st.pin_irq_flag))
		else $error("Write changed the flag");

	ack_reads_zero_a: assert property (acc.rsel == PAGPIO_REG_SC |-> !rd_byte[`PAGPIO_SC_ACK])
		else $error("Acknowledge bit read as one");

	irq_gate_a: assert property (o_irq == ((st.pin_irq_flag && st.pin_irq_request_enable) ||
		(|(st.evt_status & st.evt_mask))))
		else $error("Interrupt output mismatch");

	edge_mode_quiet_a: assert property (
		!st.pin_irq_detect_mode && !(|edge_hit) && !st.pin_irq_flag |=> !st.pin_irq_flag)
		else $error("Flag set without an edge in edge mode");

	unselected_quiet_a: assert property (st.pin_irq_select == 8'h00 |-> detect == 8'h00)
		else $error("Unselected pin raised an event");

	pin_to_edge_a: assert property (
		st.pin_irq_select[0] && !st.pin_irq_polarity_select[0] && st.sync2[0] &&
		!st.sync1[0] && (st.pin_irq_select == $past(st.pin_irq_select)) &&
		(st.pin_irq_polarity_select == $past(st.pin_irq_polarity_select))
		|=> ##1 st.pin_irq_flag)
		else $error("Falling pin edge lost");

	sequence dir_write_s;
		acc.wr && (acc.wsel == PAGPIO_REG_DIR);
	endsequence

	sequence pull_write_s;
		acc.wr && (acc.wsel == PAGPIO_REG_PULL);
	endsequence

	sequence slew_write_s;
		acc.wr && (acc.wsel == PAGPIO_REG_SLEW);
	endsequence

	sequence drive_write_s;
		acc.wr && (acc.wsel == PAGPIO_REG_DRIVE);
	endsequence

	dir_write_oe_a: assert property (
		dir_write_s |=> ##1 o_pin_oe == $past(acc.wdata, 2))
		else $error("Direction write not applied");

	pull_write_a: assert property (
		pull_write_s |=> ##1 o_pull_enable == ($past(acc.wdata, 2) & ~o_pin_oe))
		else $error("Pull enable write not applied");

	slew_write_a: assert property (
		slew_write_s |=> ##1 o_slew_enable == ($past(acc.wdata, 2) & o_pin_oe))
		else $error("Slew write not applied");

	drive_write_a: assert property (
		drive_write_s |=> ##1 o_drive_high == ($past(acc.wdata, 2) & o_pin_oe))
		else $error("Drive write not applied");

	pull_up_default_a: assert property (
		(o_pull_down & ~st.pin_irq_polarity_select) == 8'h00)
		else $error("Pull-down on low-polarity pin");

	pull_down_on_a: assert property (
		o_pull_down == (o_pull_enable & st.pin_irq_select & st.pin_irq_polarity_select))
		else $error("Pull-down missing on high-polarity pin");

	level_sets_flag_a: assert property (
		st.pin_irq_detect_mode && (|lvl_now) |=> st.pin_irq_flag)
		else $error("Asserted level did not set the flag");

	flag_only_event_a: assert property (
		!(|detect) && !ack_wr |=> st.pin_irq_flag == $past(st.pin_irq_flag))
		else $error("Flag moved without event or acknowledge");

	event_sticky_a: assert property (
		(|detect) |=> st.pin_irq_flag && ((st.evt_status & $past(detect)) == $past(detect)))
		else $error("Detection not recorded");

	unselected_pin_a: assert property (
		(detect & ~st.pin_irq_select) == 8'h00)
		else $error("Event on unselected pin");

	irq_masked_off_a: assert property (
		!st.pin_irq_request_enable && ((st.evt_status & st.evt_mask) == 8'h00) |-> !o_irq)
		else $error("Interrupt without enable");

	flag_raises_irq_a: assert property (
		st.pin_irq_flag && st.pin_irq_request_enable |-> o_irq)
		else $error("Enabled flag gave no interrupt");

	out_read_latch_a: assert property (
		(acc.rsel == PAGPIO_REG_DATA) && (&st.port_direction) |->
		rd_byte == st.port_data_latch)
		else $error("Output pin read not from latch");

	in_read_pin_a: assert property (
		(acc.rsel == PAGPIO_REG_DATA) && (st.port_direction == 8'h00) |->
		rd_byte == st.sync2)
		else $error("Input pin read not from pin");

	latch_only_write_a: assert property (
		$changed(o_pin_out) |-> $past(acc.wr && (acc.wsel == PAGPIO_REG_DATA)))
		else $error("Pin output moved without data write");

	oe_only_write_a: assert property (
		$changed(o_pin_oe) |-> $past(acc.wr && (acc.wsel == PAGPIO_REG_DIR)))
		else $error("Output enable moved without direction write");

endmodule : pagpio_top

// ### shared/pagpio_params.svh
/*
 Offsets, field positions, reset values and bus codes of the port A GPIO block.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PAGPIO_PARAMS_SVH
`define PAGPIO_PARAMS_SVH

`define PAGPIO_OFS_DATA 12'h000
`define PAGPIO_OFS_DIR 12'h004
`define PAGPIO_OFS_PULL 12'h008
`define PAGPIO_OFS_SLEW 12'h00C
`define PAGPIO_OFS_DRIVE 12'h010
`define PAGPIO_OFS_SC 12'h014
`define PAGPIO_OFS_PSEL 12'h018
`define PAGPIO_OFS_POL 12'h01C
`define PAGPIO_OFS_EVT 12'h020
`define PAGPIO_OFS_MASK 12'h024

`define PAGPIO_SC_FLAG 3
`define PAGPIO_SC_ACK 2
`define PAGPIO_SC_IE 1
`define PAGPIO_SC_MODE 0

`define PAGPIO_RST_BYTE 8'h00
`define PAGPIO_RST_WORD 32'h0000_0000
`define PAGPIO_RESP_OKAY 2'h0
`define PAGPIO_RESP_SLVERR 2'h2

`endif

// ### shared/pagpio_pkg.sv
/*
 Types and address decode of the port A GPIO block.
 Assumes the params header sits on the include path.
*/
`include "pagpio_params.svh"
package pagpio_pkg;

	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} pagpio_axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pagpio_axil_rsp_type;

	typedef enum logic [3:0] {
		PAGPIO_REG_DATA, PAGPIO_REG_DIR, PAGPIO_REG_PULL, PAGPIO_REG_SLEW,
		PAGPIO_REG_DRIVE, PAGPIO_REG_SC, PAGPIO_REG_PSEL, PAGPIO_REG_POL,
		PAGPIO_REG_EVT, PAGPIO_REG_MASK, PAGPIO_REG_NONE
	} pagpio_reg_type;

	typedef struct packed {
		logic wr;
		pagpio_reg_type wsel;
		logic [7:0] wdata;
		pagpio_reg_type rsel;
	} pagpio_acc_type;

	function automatic pagpio_reg_type pagpio_decode(input logic [11:0] addr);
		case (addr)
			`PAGPIO_OFS_DATA: return PAGPIO_REG_DATA;
			`PAGPIO_OFS_DIR: return PAGPIO_REG_DIR;
			`PAGPIO_OFS_PULL: return PAGPIO_REG_PULL;
			`PAGPIO_OFS_SLEW: return PAGPIO_REG_SLEW;
			`PAGPIO_OFS_DRIVE: return PAGPIO_REG_DRIVE;
			`PAGPIO_OFS_SC: return PAGPIO_REG_SC;
			`PAGPIO_OFS_PSEL: return PAGPIO_REG_PSEL;
			`PAGPIO_OFS_POL: return PAGPIO_REG_POL;
			`PAGPIO_OFS_EVT: return PAGPIO_REG_EVT;
			`PAGPIO_OFS_MASK: return PAGPIO_REG_MASK;
			default: return PAGPIO_REG_NONE;
		endcase
	endfunction : pagpio_decode

endpackage : pagpio_pkg

// ### rtl/pagpio_axil.sv
/*
 AXI4-Lite slave front end: turns bus transfers into register strobes.
 Assumes a master that keeps one write and one read in flight at most.
*/
`timescale 1ns/1ps
`include "pagpio_params.svh"
module pagpio_axil
	import pagpio_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire pagpio_axil_req_type i_axil,
	output pagpio_axil_rsp_type o_axil,
	output pagpio_acc_type o_acc,
	input wire logic [7:0] i_rdata
);

	typedef struct packed {
		pagpio_axil_rsp_type rsp;
		pagpio_acc_type acc;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [7:0] w_byte;
		logic w_lane0;
		logic ar_held;
	} pagpio_slv_state_type;

	pagpio_slv_state_type st;
	pagpio_slv_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.acc.wr = 1'b0;
		if (st.rsp.awready && i_axil.awvalid) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = i_axil.awaddr;
		end
		if (st.rsp.wready && i_axil.wvalid) begin
			next_st.w_held = 1'b1;
			next_st.w_byte = i_axil.wdata[7:0];
			next_st.w_lane0 = i_axil.wstrb[0];
		end
		if (st.rsp.bvalid && i_axil.bready) begin
			next_st.rsp.bvalid = 1'b0;
		end
		// Address and data may arrive in either order
		if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.rsp.bvalid = 1'b1;
			next_st.acc.wsel = pagpio_decode(st.aw_addr);
			next_st.acc.wdata = st.w_byte;
			next_st.acc.wr = st.w_lane0 && (pagpio_decode(st.aw_addr) != PAGPIO_REG_NONE);
			next_st.rsp.bresp = (pagpio_decode(st.aw_addr) == PAGPIO_REG_NONE) ?
				`PAGPIO_RESP_SLVERR : `PAGPIO_RESP_OKAY;
		end
		if (st.rsp.rvalid && i_axil.rready) begin
			next_st.rsp.rvalid = 1'b0;
		end
		if (st.ar_held) begin
			next_st.ar_held = 1'b0;
			next_st.rsp.rvalid = 1'b1;
			next_st.rsp.rdata = {24'h00_0000, i_rdata};
			next_st.rsp.rresp = (st.acc.rsel == PAGPIO_REG_NONE) ?
				`PAGPIO_RESP_SLVERR : `PAGPIO_RESP_OKAY;
		end
		if (st.rsp.arready && i_axil.arvalid) begin
			next_st.ar_held = 1'b1;
			next_st.acc.rsel = pagpio_decode(i_axil.araddr);
		end
		// Ready flags are stored so that every bus output is a flop
		next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
		next_st.rsp.wready = !next_st.w_held && !next_st.rsp.bvalid;
		next_st.rsp.arready = !next_st.ar_held && !next_st.rsp.rvalid;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
			st.acc.wsel <= PAGPIO_REG_NONE;
			st.acc.rsel <= PAGPIO_REG_NONE;
			st.rsp.awready <= 1'b1;
			st.rsp.wready <= 1'b1;
			st.rsp.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_axil = st.rsp;
	assign o_acc = st.acc;

endmodule : pagpio_axil

// ### tb/pagpio_pad_model.sv
/*
 Pad model of the eight port A pins: driver, outside source, pulls.
 Assumes the bench moves i_ext_val and i_ext_en just after clock edges.
*/
`timescale 1ns/1ps
module pagpio_pad_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_pin_out,
	input wire logic [7:0] i_pin_oe,
	input wire logic [7:0] i_pull_enable,
	input wire logic [7:0] i_pull_down,
	input wire logic [7:0] i_ext_val,
	input wire logic [7:0] i_ext_en,
	output logic [7:0] o_pin
);
	logic [7:0] noise = 8'h00;
	// Undriven pads wander so a stale level never passes
	always @(posedge i_sys_clk) noise <= ~noise;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_pin_oe[i]) o_pin[i] = i_pin_out[i];
			else if (i_ext_en[i]) o_pin[i] = i_ext_val[i];
			else if (i_pull_enable[i]) o_pin[i] = ~i_pull_down[i];
			else o_pin[i] = noise[i];
		end
	end
endmodule : pagpio_pad_model

// ### tb/tb.sv
/*
 Self-checking bench of the port A GPIO block: bus master, byte model, pads.
 Assumes pagpio_top and the pad model; one 250 MHz clock.
*/
`timescale 1ns/1ps
`include "pagpio_params.svh"
module tb
	import pagpio_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	pagpio_axil_req_type req = '0;
	pagpio_axil_rsp_type rsp;
	logic [7:0] pin, p_out, p_oe, p_pe, p_pd, p_se, p_dh;
	logic [7:0] ext_val = 8'hff;
	logic [7:0] ext_en = 8'h00;
	logic irq;
	int num_errors = 0;
	int num_checks = 0;
	logic [7:0] lfsr = 8'h5e;
	logic [7:0] m [10] = '{default: 8'h00};
	logic [31:0] rd;
	logic [1:0] rs;
	logic [7:0] d;

	initial forever #2 clk = ~clk;

	pagpio_top uut (.i_sys_clk(clk), .i_rstn(rstn), .i_axil(req), .o_axil(rsp),
		.i_pin(pin), .o_pin_out(p_out), .o_pin_oe(p_oe), .o_pull_enable(p_pe),
		.o_pull_down(p_pd), .o_slew_enable(p_se), .o_drive_high(p_dh), .o_irq(irq));
	pagpio_pad_model pads (.i_sys_clk(clk), .i_pin_out(p_out), .i_pin_oe(p_oe),
		.i_pull_enable(p_pe), .i_pull_down(p_pd), .i_ext_val(ext_val),
		.i_ext_en(ext_en), .o_pin(pin));

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Master holds each channel until its own ready edge
	task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		if (wr) begin
			req.awaddr <= a;
			req.wdata <= wd;
			req.wstrb <= 4'hf;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
			req.bready <= 1'b1;
			do begin
				@(posedge clk);
				n++;
				if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
				if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
			end while (rsp.bvalid !== 1'b1 && n < 200);
			req.bready <= 1'b0;
			rs = rsp.bresp;
		end else begin
			req.araddr <= a;
			req.arvalid <= 1'b1;
			req.rready <= 1'b1;
			do begin
				@(posedge clk);
				n++;
				if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
			end while (rsp.rvalid !== 1'b1 && n < 200);
			req.rready <= 1'b0;
			rd = rsp.rdata;
			rs = rsp.rresp;
		end
		if (n >= 200) begin
			num_errors++;
			give_verdict();
		end
	endtask : axi

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		axi(1'b1, a, {24'h00_0000, v});
		chk(rs, `PAGPIO_RESP_OKAY);
		m[a[5:2]] = v;
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		axi(1'b0, a, 32'h0000_0000);
		chk(rs, `PAGPIO_RESP_OKAY);
		chk(rd, {24'h00_0000, e});
	endtask : rdc

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	initial begin
		tick(16);
		rstn <= 1'b1;
		tick(1);
		chk(p_oe, 8'h00);
		chk(p_pe, 8'h00);
		chk(irq, 1'b0);
		for (int i = 1; i < 10; i++) rdc(12'(i * 4), 8'h00);
		axi(1'b0, 12'h028, 32'h0000_0000);
		chk(rs, `PAGPIO_RESP_SLVERR);
		chk(rd, 32'h0000_0000);
		axi(1'b1, 12'h0fc, 32'h0000_00ff);
		chk(rs, `PAGPIO_RESP_SLVERR);
		$display("test reset done");
		ext_en <= 8'hff;
		for (int k = 0; k < 12; k++) begin
			ext_val <= rnd();
			for (int r = 0; r < 5; r++) wr(12'(r * 4), rnd());
			wr(`PAGPIO_OFS_PSEL, rnd());
			wr(`PAGPIO_OFS_POL, rnd());
			d = m[1];
			rdc(`PAGPIO_OFS_DATA, (m[0] & d) | (ext_val & ~d));
			chk(p_oe, d);
			chk(p_out, m[0]);
			chk(p_pe, m[2] & ~d);
			chk(p_pd, m[2] & ~d & m[6] & m[7]);
			chk(p_se, m[3] & d);
			chk(p_dh, m[4] & d);
			for (int r = 1; r < 8; r++) if (r != 5) rdc(12'(r * 4), m[r]);
		end
		$display("test pins done");
		wr(`PAGPIO_OFS_DIR, 8'h00);
		wr(`PAGPIO_OFS_POL, 8'h00);
		wr(`PAGPIO_OFS_PSEL, 8'h01);
		wr(`PAGPIO_OFS_MASK, 8'h00);
		ext_val <= 8'hff;
		tick(4);
		// Ack after setup hides any false flag from reconfiguring
		wr(`PAGPIO_OFS_SC, 8'h06);
		rdc(`PAGPIO_OFS_SC, 8'h02);
		ext_val <= 8'hfd;
		tick(4);
		rdc(`PAGPIO_OFS_SC, 8'h02);
		ext_val <= 8'hfc;
		tick(4);
		chk(irq, 1'b1);
		rdc(`PAGPIO_OFS_SC, 8'h0a);
		wr(`PAGPIO_OFS_SC, 8'h00);
		tick(2);
		chk(irq, 1'b0);
		rdc(`PAGPIO_OFS_SC, 8'h08);
		wr(`PAGPIO_OFS_SC, 8'h04);
		rdc(`PAGPIO_OFS_SC, 8'h00);
		wr(`PAGPIO_OFS_SC, 8'h05);
		tick(4);
		rdc(`PAGPIO_OFS_SC, 8'h09);
		ext_val <= 8'hfd;
		tick(4);
		wr(`PAGPIO_OFS_SC, 8'h05);
		rdc(`PAGPIO_OFS_SC, 8'h01);
		// Leave level mode first: a polarity flip would assert the pin
		wr(`PAGPIO_OFS_SC, 8'h04);
		wr(`PAGPIO_OFS_POL, 8'h01);
		ext_val <= 8'hfc;
		tick(4);
		rdc(`PAGPIO_OFS_SC, 8'h00);
		ext_val <= 8'hfd;
		tick(4);
		rdc(`PAGPIO_OFS_SC, 8'h08);
		$display("test flag done");
		wr(`PAGPIO_OFS_EVT, 8'hff);
		rdc(`PAGPIO_OFS_EVT, 8'h00);
		ext_val <= 8'hfc;
		tick(4);
		ext_val <= 8'hfd;
		tick(4);
		chk(irq, 1'b0);
		wr(`PAGPIO_OFS_MASK, 8'h01);
		tick(2);
		chk(irq, 1'b1);
		rdc(`PAGPIO_OFS_EVT, 8'h01);
		wr(`PAGPIO_OFS_EVT, 8'h01);
		tick(2);
		chk(irq, 1'b0);
		rdc(`PAGPIO_OFS_EVT, 8'h00);
		$display("test events done");
		give_verdict();
	end
endmodule : tb
